// ===== include/csc_defines.svh
// constants for the cold-reset strap capture and pin default logic
// assumes a single 200 MHz system clock
`ifndef CSC_DEFINES_SVH
`define CSC_DEFINES_SVH

// ============================================================
// strap vector layout
`define CSC_STRAP_W       8
`define CSC_SB_MULT_MSB   2
`define CSC_SB_MULT_LSB   0
`define CSC_SB_ORDER      3
`define CSC_SB_RSV_ACK    4
`define CSC_SB_RSV_STB    5
`define CSC_SB_TIMER      6
`define CSC_SB_RSV_A17    7
`define CSC_STRAP_RST     8'h80

// ============================================================
// clock multiplier codes and ratios
`define CSC_MULT_X2       3'h0
`define CSC_MULT_X3       3'h1
`define CSC_MULT_X4       3'h2
`define CSC_RATIO_X2      3'h2
`define CSC_RATIO_X3      3'h3
`define CSC_RATIO_X4      3'h4
`define CSC_RATIO_BAD     3'h0

// ============================================================
// general-purpose pin map
`define CSC_PIO_W         16
`define CSC_PIO_SER_DO    10
`define CSC_PIO_SER_CLK   9
`define CSC_PIO_SER_CS    8
`define CSC_PIO_SER_DI    7
`define CSC_PIO_CTS       15
`define CSC_PIO_DSR       14
`define CSC_PIO_DTR       13
`define CSC_PIO_RTS       12
`define CSC_PIO_UTX0      5
`define CSC_PIO_UTX1      3
`define CSC_PIO_RST_OE    16'h0700
`define CSC_PIO_RST_LVL   16'h0100

// ============================================================
// debug block address width (memory data bits 31..4)
`define CSC_BLK_W         28

// ============================================================
// timing
`define CSC_CLK_PERIOD_NS 5
`define CSC_COLD_MIN_MS   120
`define CSC_COLD_MIN_CYC  \
  ((`CSC_COLD_MIN_MS * 1000000 + `CSC_CLK_PERIOD_NS - 1) / `CSC_CLK_PERIOD_NS)
`define CSC_CNT_W         32

`endif

// ===== include/csc_pkg.sv
// types shared by the strap capture block
// assumes csc_defines.svh is on the include path
`include "csc_defines.svh"

package csc_pkg;
  typedef logic [2:0]              csc_mult_t;
  typedef logic [2:0]              csc_ratio_t;
  typedef logic [`CSC_STRAP_W-1:0] csc_strap_t;
  typedef enum {CSC_CAPTURE, CSC_LOCKED} csc_state_t;
endpackage

// ===== rtl/csc_pin_mux.sv
// per-pin output mux for the shared general-purpose pins
// assumes hold_i is high for the whole cold reset
`include "csc_defines.svh"

module csc_pin_mux #(
  parameter int                  N       = `CSC_PIO_W,
  parameter logic [N-1:0]        RST_OE  = `CSC_PIO_RST_OE,
  parameter logic [N-1:0]        RST_LVL = `CSC_PIO_RST_LVL
) (
  input  wire logic         clk_sys_i,   // system clock
  input  wire logic         reset_i,     // sync reset, active high
  input  wire logic         hold_i,      // force reset defaults
  input  wire logic [N-1:0] gpio_en_i,   // pin used as general purpose
  input  wire logic [N-1:0] gpio_out_i,  // general-purpose level
  input  wire logic [N-1:0] gpio_oe_i,   // general-purpose direction
  input  wire logic [N-1:0] func_out_i,  // function level
  input  wire logic [N-1:0] func_oe_i,   // function direction
  input  wire logic [N-1:0] pin_in_i,    // pad level
  output logic      [N-1:0] pin_out_o,   // pad drive level
  output logic      [N-1:0] pin_oe_o,    // pad drive enable
  output logic      [N-1:0] pin_in_q_o   // registered pad level
);

  // ============================================================
  // one registered cell per pin
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_pin
      always_ff @(posedge clk_sys_i) begin
        if (reset_i || hold_i) begin
          pin_oe_o[g]  <= RST_OE[g];
          pin_out_o[g] <= RST_LVL[g];
        end else if (gpio_en_i[g]) begin
          pin_oe_o[g]  <= gpio_oe_i[g];
          pin_out_o[g] <= gpio_out_i[g];
        end else begin
          pin_oe_o[g]  <= func_oe_i[g];
          pin_out_o[g] <= func_out_i[g];
        end
      end

      always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
          pin_in_q_o[g] <= 1'b0;
        end else begin
          pin_in_q_o[g] <= pin_in_i[g];
        end
      end
    end
  endgenerate

endmodule

// ===== rtl/csc_strap_cfg.sv
// cold-reset strap capture, debug pin reporting and pin defaults
// assumes straps and cold reset are synchronous to clk_sys_i
//
// Notes on behaviour
// - sample straps during cold reset, set config
// - multiplier code 0,1,2 gives x2,x3,x4
// - strap bit 3: 0 little, 1 big endian
// - strap bit 6: 0 enables timer interrupt
// - cpu/dma pin high for cpu, low dma
// - instr/data pin low data, high fetch
// - strobe at start with block address out
// - acknowledge pin marks returned data acknowledge
// - uart transmit pins reset as inputs
// - serial out, clock low; select high
// - serial data-in pin resets as input
// - satellite boot routes serial pins to eeprom
// - chip select picks general serial peripheral
// - serial pins map to pio 10,9,8,7
// - modem pins map to pio 15..12
`include "csc_defines.svh"

module csc_strap_cfg #(
  parameter int COLD_MIN_CYC = `CSC_COLD_MIN_CYC
) (
  input  wire logic                   clk_sys_i,        // system clock
  input  wire logic                   reset_i,          // sync reset
  input  wire logic                   cold_reset_n_i,   // cold reset, low
  input  wire logic [2:0]             pcst_i,           // multiplier strap
  input  wire logic                   addr17_i,         // strap bit 7 pin
  input  wire logic                   dbg_cpu_dma_n_i,  // pad level
  output logic                        dbg_cpu_dma_n_o,  // pad drive
  output logic                        dbg_cpu_dma_oe_o, // pad enable
  input  wire logic                   dbg_ack_n_i,      // pad level
  output logic                        dbg_ack_n_o,      // pad drive
  output logic                        dbg_ack_oe_o,     // pad enable
  input  wire logic                   dbg_ads_n_i,      // pad level
  output logic                        dbg_ads_n_o,      // pad drive
  output logic                        dbg_ads_oe_o,     // pad enable
  input  wire logic                   dbg_i_d_n_i,      // pad level
  output logic                        dbg_i_d_n_o,      // pad drive
  output logic                        dbg_i_d_oe_o,     // pad enable
  output logic [`CSC_BLK_W-1:0]       dbg_blk_addr_o,   // block address
  input  wire logic                   txn_start_i,      // transaction start
  input  wire logic                   txn_ack_i,        // data acknowledge
  input  wire logic                   txn_dma_i,        // from dma engine
  input  wire logic                   txn_data_i,       // data, not fetch
  input  wire logic [`CSC_BLK_W-1:0]  txn_blk_addr_i,   // block address
  output csc_pkg::csc_mult_t          clk_mult_code_o,  // multiplier code
  output csc_pkg::csc_ratio_t         core_clk_ratio_o, // core clk ratio
  output logic                        byte_order_strap_o, // 1 big endian
  output logic                        timer_irq_strap_o,  // 1 disables
  output logic                        timer_irq_en_o,   // timer irq on
  output logic                        strap_valid_o,    // straps locked
  output logic                        strap_fault_o,    // reserved misuse
  output logic                        cold_short_o,     // cold too short
  input  wire logic                   sat_boot_i,       // satellite boot
  input  wire logic                   ser_do_i,         // serial data out
  input  wire logic                   ser_clk_i,        // serial clock
  input  wire logic                   ser_cs_n_i,       // serial select
  input  wire logic                   boot_rom_do_i,    // eeprom data out
  input  wire logic                   boot_rom_clock_i, // eeprom clock
  output logic                        ser_di_o,         // serial data in
  input  wire logic [1:0]             uart_tx_i,        // uart tx levels
  input  wire logic [1:0]             uart_tx_en_i,     // tx pins enabled
  input  wire logic                   uart_dtr_n_i,     // modem dtr
  input  wire logic                   uart_rts_n_i,     // modem rts
  output logic                        uart_cts_n_o,     // modem cts
  output logic                        uart_dsr_n_o,     // modem dsr
  input  wire logic [`CSC_PIO_W-1:0]  gpio_en_i,        // pin as gpio
  input  wire logic [`CSC_PIO_W-1:0]  gpio_out_i,       // gpio level
  input  wire logic [`CSC_PIO_W-1:0]  gpio_oe_i,        // gpio direction
  input  wire logic [`CSC_PIO_W-1:0]  pio_in_i,         // pad levels
  output logic [`CSC_PIO_W-1:0]       pio_out_o,        // pad drive
  output logic [`CSC_PIO_W-1:0]       pio_oe_o          // pad enables
);
  import csc_pkg::*;

  csc_state_t                state_r;
  csc_strap_t                strap_r;
  csc_strap_t                strap_pins;
  logic                      run;
  logic                      release_ev;
  logic                      cold_q_r;
  logic [`CSC_CNT_W-1:0]     cold_cnt_r;
  logic [`CSC_PIO_W-1:0]     func_out;
  logic [`CSC_PIO_W-1:0]     func_oe;
  logic [`CSC_PIO_W-1:0]     pin_q;

  // ============================================================
  // strap capture
  assign strap_pins = {addr17_i, dbg_cpu_dma_n_i, dbg_ads_n_i,
                       dbg_ack_n_i, dbg_i_d_n_i, pcst_i};
  assign release_ev = cold_reset_n_i && !cold_q_r;
  assign run        = (state_r == CSC_LOCKED) && cold_reset_n_i;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cold_q_r <= 1'b0;
    end else begin
      cold_q_r <= cold_reset_n_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_r <= CSC_CAPTURE;
    end else begin
      case (state_r)
        CSC_CAPTURE: if (release_ev) state_r <= CSC_LOCKED;
        CSC_LOCKED:  if (!cold_reset_n_i) state_r <= CSC_CAPTURE;
        default:     state_r <= CSC_CAPTURE;
      endcase
    end
  end

  // track pins while cold reset is low; last value stays at release
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      strap_r <= `CSC_STRAP_RST;
    end else if (!cold_reset_n_i) begin
      strap_r <= strap_pins;
    end
  end

  assign clk_mult_code_o    = strap_r[`CSC_SB_MULT_MSB:`CSC_SB_MULT_LSB];
  assign byte_order_strap_o = strap_r[`CSC_SB_ORDER];
  assign timer_irq_strap_o  = strap_r[`CSC_SB_TIMER];
  assign timer_irq_en_o     = !strap_r[`CSC_SB_TIMER];
  assign strap_valid_o      = run;

  always_comb begin
    case (clk_mult_code_o)
      `CSC_MULT_X2: core_clk_ratio_o = `CSC_RATIO_X2;
      `CSC_MULT_X3: core_clk_ratio_o = `CSC_RATIO_X3;
      `CSC_MULT_X4: core_clk_ratio_o = `CSC_RATIO_X4;
      default:      core_clk_ratio_o = `CSC_RATIO_BAD;
    endcase
  end

  // reserved codes and reserved bits the board must not drive
  assign strap_fault_o = (core_clk_ratio_o == `CSC_RATIO_BAD) ||
                         strap_r[`CSC_SB_RSV_ACK] ||
                         strap_r[`CSC_SB_RSV_STB] ||
                         !strap_r[`CSC_SB_RSV_A17];

  // ============================================================
  // cold reset length check
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || cold_reset_n_i) begin
      cold_cnt_r <= '0;
    end else if (cold_cnt_r != '1) begin
      cold_cnt_r <= cold_cnt_r + `CSC_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cold_short_o <= 1'b0;
    end else if (release_ev) begin
      cold_short_o <= (cold_cnt_r < `CSC_CNT_W'(COLD_MIN_CYC));
    end
  end

  // ============================================================
  // debug pins: straps in cold reset, transaction report afterwards
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || !run) begin
      dbg_ads_n_o     <= 1'b1;
      dbg_ack_n_o     <= 1'b1;
      dbg_cpu_dma_n_o <= 1'b1;
      dbg_i_d_n_o     <= 1'b1;
    end else begin
      dbg_ads_n_o <= !txn_start_i;
      dbg_ack_n_o <= !txn_ack_i;
      if (txn_start_i || txn_ack_i) begin
        dbg_cpu_dma_n_o <= !txn_dma_i;
        dbg_i_d_n_o     <= !txn_data_i;
      end else begin
        dbg_cpu_dma_n_o <= 1'b1;
        dbg_i_d_n_o     <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      dbg_blk_addr_o <= '0;
    end else if (run && txn_start_i) begin
      dbg_blk_addr_o <= txn_blk_addr_i;
    end
  end

  // pins are inputs during cold reset so the straps can be read
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      dbg_cpu_dma_oe_o <= 1'b0;
      dbg_ack_oe_o     <= 1'b0;
      dbg_ads_oe_o     <= 1'b0;
      dbg_i_d_oe_o     <= 1'b0;
    end else begin
      dbg_cpu_dma_oe_o <= run;
      dbg_ack_oe_o     <= run;
      dbg_ads_oe_o     <= run;
      dbg_i_d_oe_o     <= run;
    end
  end

  // ============================================================
  // shared pin functions
  always_comb begin
    func_out = '0;
    func_oe  = '0;
    func_oe[`CSC_PIO_SER_DO]   = 1'b1;
    func_oe[`CSC_PIO_SER_CLK]  = 1'b1;
    func_oe[`CSC_PIO_SER_CS]   = 1'b1;
    func_out[`CSC_PIO_SER_DO]  = sat_boot_i ? boot_rom_do_i : ser_do_i;
    func_out[`CSC_PIO_SER_CLK] = sat_boot_i ? boot_rom_clock_i : ser_clk_i;
    // general peripheral stays deselected while the eeprom is read
    func_out[`CSC_PIO_SER_CS]  = sat_boot_i ? 1'b1 : ser_cs_n_i;
    func_oe[`CSC_PIO_DTR]      = 1'b1;
    func_oe[`CSC_PIO_RTS]      = 1'b1;
    func_out[`CSC_PIO_DTR]     = uart_dtr_n_i;
    func_out[`CSC_PIO_RTS]     = uart_rts_n_i;
    func_oe[`CSC_PIO_UTX0]     = uart_tx_en_i[0];
    func_oe[`CSC_PIO_UTX1]     = uart_tx_en_i[1];
    func_out[`CSC_PIO_UTX0]    = uart_tx_i[0];
    func_out[`CSC_PIO_UTX1]    = uart_tx_i[1];
  end

  csc_pin_mux #(
    .N       (`CSC_PIO_W),
    .RST_OE  (`CSC_PIO_RST_OE),
    .RST_LVL (`CSC_PIO_RST_LVL)
  ) csc_pin_mux_i (
    .clk_sys_i  (clk_sys_i),
    .reset_i    (reset_i),
    .hold_i     (!cold_reset_n_i),
    .gpio_en_i  (gpio_en_i),
    .gpio_out_i (gpio_out_i),
    .gpio_oe_i  (gpio_oe_i),
    .func_out_i (func_out),
    .func_oe_i  (func_oe),
    .pin_in_i   (pio_in_i),
    .pin_out_o  (pio_out_o),
    .pin_oe_o   (pio_oe_o),
    .pin_in_q_o (pin_q)
  );

  assign ser_di_o     = pin_q[`CSC_PIO_SER_DI];
  assign uart_cts_n_o = pin_q[`CSC_PIO_CTS];
  assign uart_dsr_n_o = pin_q[`CSC_PIO_DSR];

  // ============================================================
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  strap_capture_a: assert property (
    $rose(cold_reset_n_i) && !$past(reset_i) |->
      timer_irq_strap_o == $past(dbg_cpu_dma_n_i) &&
      clk_mult_code_o == $past(pcst_i))
    else $error("strap not taken from last cold reset cycle");

  strap_hold_a: assert property (
    cold_reset_n_i && $past(cold_reset_n_i) |-> $stable(strap_r))
    else $error("strap changed outside cold reset");

  mult_ratio_a: assert property (
    clk_mult_code_o == `CSC_MULT_X3 |-> core_clk_ratio_o == `CSC_RATIO_X3)
    else $error("multiplier code 1 not times three");

  timer_en_a: assert property (
    $rose(cold_reset_n_i) && !$past(dbg_cpu_dma_n_i) |->
      timer_irq_en_o [*2])
    else $error("timer interrupt not enabled by low strap");

  strobe_addr_a: assert property (
    run && txn_start_i |=>
      !dbg_ads_n_o && dbg_blk_addr_o == $past(txn_blk_addr_i))
    else $error("strobe or block address missing");

  cpu_dma_a: assert property (
    run && txn_ack_i |=> dbg_cpu_dma_n_o == !$past(txn_dma_i))
    else $error("cpu versus dma level wrong");

  instr_data_a: assert property (
    run && txn_start_i && txn_data_i |=> !dbg_i_d_n_o && dbg_i_d_oe_o)
    else $error("data transaction not reported low");

  ack_pin_a: assert property (
    run && txn_ack_i |=> !dbg_ack_n_o ##1 (dbg_ack_n_o || $past(txn_ack_i)))
    else $error("acknowledge pin wrong");

  serial_dflt_a: assert property (
    !cold_reset_n_i |=> pio_oe_o[`CSC_PIO_SER_DO] &&
      !pio_out_o[`CSC_PIO_SER_DO] && !pio_out_o[`CSC_PIO_SER_CLK] &&
      pio_out_o[`CSC_PIO_SER_CS] && !pio_oe_o[`CSC_PIO_SER_DI])
    else $error("serial pin reset default wrong");

  uart_tx_in_a: assert property (
    !cold_reset_n_i |=> !pio_oe_o[`CSC_PIO_UTX0] && !pio_oe_o[`CSC_PIO_UTX1])
    else $error("uart transmit pin driven in reset");

  dbg_release_a: assert property (
    !cold_reset_n_i |=> !dbg_ads_oe_o ##1 !dbg_ads_oe_o || cold_reset_n_i)
    else $error("debug pin driven during cold reset");

  release_cv: cover property ($rose(cold_reset_n_i) ##1 strap_valid_o);
  dma_txn_cv: cover property (run && txn_start_i && txn_dma_i);
  boot_cv:    cover property (run && sat_boot_i && !gpio_en_i[10]);
  short_cv:   cover property ($rose(cold_short_o));

endmodule

// ===== tb/csc_board_model.sv
// board side model: cold reset controller, strap resistors, trace pins
// assumes the debug pads are resolved here from the device pad enables
`include "csc_defines.svh"

module csc_board_model (
  input  wire logic       clk_sys_i,      // system clock
  input  wire logic [3:0] dbg_oe_i,       // {dma, ads, ack, i_d} enables
  input  wire logic [3:0] dbg_out_i,      // {dma, ads, ack, i_d} levels
  output logic            cold_reset_n_o, // cold reset, low active
  output logic [2:0]      pcst_o,         // multiplier strap pins
  output logic            addr17_o,       // strap bit 7 pin
  output logic [3:0]      dbg_pad_o       // resolved debug pad levels
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] pull_r = `CSC_STRAP_RST;

  initial begin
    cold_reset_n_o = 1'b0;
  end

  // ============================================================
  // cold reset pulse with a strap pattern on the resistors
  task automatic cold_cycle(input logic [7:0] s, input int n);
    @(negedge clk_sys_i);
    cold_reset_n_o = 1'b0;
    pull_r = s;
    repeat (n) @(negedge clk_sys_i);
    cold_reset_n_o = 1'b1;
  endtask

  // ============================================================
  // pads: the device drive wins, else the strap resistor level
  assign dbg_pad_o = (dbg_oe_i & dbg_out_i) | (~dbg_oe_i & pull_r[6:3]);

  // trace and address pins move every cycle once the straps are taken
  always @(negedge clk_sys_i) begin
    if (cold_reset_n_o) begin
      {addr17_o, pcst_o} <= ~{addr17_o, pcst_o};
    end else begin
      {addr17_o, pcst_o} <= {pull_r[7], pull_r[2:0]};
    end
  end
endmodule

// ===== tb/csc_strap_cfg_tb.sv
// self-checking bench for the cold reset strap capture block
// assumes the board model drives cold reset, straps and debug pads
`include "csc_defines.svh"

module csc_strap_cfg_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import csc_pkg::*;

  localparam int COLD = 20;
  typedef struct {
    logic kind; logic [7:0] s; int n; logic [3:0] d; logic [27:0] a;
  } csc_note_t;

  logic clk_sys_i, reset_i, cold_n, addr17, sat, s_do, s_clk, s_cs_n;
  logic b_do, b_clk, dtr_n, rts_n, ser_di, cts_n, dsr_n, valid_q;
  logic start, ack, dma, data, byte_o, tmr_s, tmr_en, valid, fault, short_o;
  logic [2:0] pcst;
  csc_mult_t code;
  csc_ratio_t ratio;
  logic [3:0] pad, oe4, out4;
  logic [1:0] tx, tx_en;
  logic [27:0] blk_a, blk_o, last_blk;
  logic [15:0] g_en, g_out, g_oe, p_in, p_out, p_oe;
  logic [10:0] strap_g;
  logic [35:0] dbg_g, pin_g;
  logic [31:0] lfsr = 32'hfe97;
  int err_count = 0;
  int comparisons = 0;
  csc_note_t notes[$];

  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  csc_board_model board_i (.clk_sys_i(clk_sys_i), .dbg_oe_i(oe4),
    .dbg_out_i(out4), .cold_reset_n_o(cold_n), .pcst_o(pcst),
    .addr17_o(addr17), .dbg_pad_o(pad));

  csc_strap_cfg #(.COLD_MIN_CYC(COLD)) csc_strap_cfg_i (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .cold_reset_n_i(cold_n),
    .pcst_i(pcst), .addr17_i(addr17),
    .dbg_cpu_dma_n_i(pad[3]), .dbg_cpu_dma_n_o(out4[3]),
    .dbg_cpu_dma_oe_o(oe4[3]), .dbg_ads_n_i(pad[2]), .dbg_ads_n_o(out4[2]),
    .dbg_ads_oe_o(oe4[2]), .dbg_ack_n_i(pad[1]), .dbg_ack_n_o(out4[1]),
    .dbg_ack_oe_o(oe4[1]), .dbg_i_d_n_i(pad[0]), .dbg_i_d_n_o(out4[0]),
    .dbg_i_d_oe_o(oe4[0]), .dbg_blk_addr_o(blk_o), .txn_start_i(start),
    .txn_ack_i(ack), .txn_dma_i(dma), .txn_data_i(data),
    .txn_blk_addr_i(blk_a), .clk_mult_code_o(code),
    .core_clk_ratio_o(ratio), .byte_order_strap_o(byte_o),
    .timer_irq_strap_o(tmr_s), .timer_irq_en_o(tmr_en),
    .strap_valid_o(valid), .strap_fault_o(fault), .cold_short_o(short_o),
    .sat_boot_i(sat), .ser_do_i(s_do), .ser_clk_i(s_clk),
    .ser_cs_n_i(s_cs_n), .boot_rom_do_i(b_do), .boot_rom_clock_i(b_clk),
    .ser_di_o(ser_di), .uart_tx_i(tx), .uart_tx_en_i(tx_en),
    .uart_dtr_n_i(dtr_n), .uart_rts_n_i(rts_n), .uart_cts_n_o(cts_n),
    .uart_dsr_n_o(dsr_n), .gpio_en_i(g_en), .gpio_out_i(g_out),
    .gpio_oe_i(g_oe), .pio_in_i(p_in), .pio_out_o(p_out), .pio_oe_o(p_oe));

  assign strap_g = {code, ratio, byte_o, tmr_s, tmr_en, fault, short_o};
  assign dbg_g   = {out4[2], out4[1], out4[3], out4[0], oe4, blk_o};
  assign pin_g   = {1'b0, ser_di, cts_n, dsr_n, p_out, p_oe};

  // ============================================================
  // helpers
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  task automatic fail(input string m);
    err_count++;
    $display("mismatch at %0t: %s", $time, m);
  endtask

  task automatic cmp_strap(input logic [10:0] g, input logic [10:0] e);
    comparisons++;
    if (g !== e) fail($sformatf("config %h, expected %h", g, e));
  endtask

  task automatic cmp_dbg(input logic [35:0] g, input logic [35:0] e);
    comparisons++;
    if (g !== e) fail($sformatf("debug pins %h, expected %h", g, e));
  endtask

  task automatic cmp_pin(input logic [35:0] g, input logic [35:0] e);
    comparisons++;
    if (g !== e) fail($sformatf("pins %h, expected %h", g, e));
  endtask

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic drain();
    int k;
    for (k = 0; k < 10 && notes.size() > 0; k++) @(posedge clk_sys_i);
    if (notes.size() > 0) begin
      fail("expected result never appeared");
      summarize();
    end
  endtask

  // expected registered pad inputs and {out, oe} of the pads
  function automatic logic [35:0] pin_exp();
    logic [15:0] fo, fe;
    fo = '0;
    fe = '0;
    fo[`CSC_PIO_SER_DO] = sat ? b_do : s_do;
    fo[`CSC_PIO_SER_CLK] = sat ? b_clk : s_clk;
    fo[`CSC_PIO_SER_CS] = sat ? 1'b1 : s_cs_n;
    fo[`CSC_PIO_DTR] = dtr_n;
    fo[`CSC_PIO_RTS] = rts_n;
    fo[`CSC_PIO_UTX0] = tx[0];
    fo[`CSC_PIO_UTX1] = tx[1];
    fe = 16'h3700;
    fe[`CSC_PIO_UTX0] = tx_en[0];
    fe[`CSC_PIO_UTX1] = tx_en[1];
    return {1'b0, p_in[`CSC_PIO_SER_DI], p_in[`CSC_PIO_CTS],
      p_in[`CSC_PIO_DSR], (g_en & g_out) | (~g_en & fo),
      (g_en & g_oe) | (~g_en & fe)};
  endfunction

  // expected {code, ratio, order, timer strap, timer enable, fault, short}
  function automatic logic [10:0] strap_exp(input csc_note_t n);
    return {n.s[2:0], n.s[2:0] == 3'h0 ? `CSC_RATIO_X2 : n.s[2:0] == 3'h1 ?
      `CSC_RATIO_X3 : n.s[2:0] == 3'h2 ? `CSC_RATIO_X4 : `CSC_RATIO_BAD,
      n.s[3], n.s[6], ~n.s[6], n.s[2:0] > 3'h2 || n.s[5:4] != 2'h0 ||
      !n.s[7], n.n < COLD};
  endfunction

  // ============================================================
  // result watcher: each appearing result takes the oldest note
  always @(posedge clk_sys_i) begin
    csc_note_t n;
    #1;
    if (!reset_i && valid === 1'b1 && valid_q !== 1'b1) begin
      if (notes.size() == 0) fail("unexpected strap lock");
      else begin
        n = notes.pop_front();
        cmp_strap(strap_g, strap_exp(n));
      end
    end
    if (out4[2] === 1'b0 || out4[1] === 1'b0) begin
      if (notes.size() == 0) fail("unexpected debug pulse");
      else begin
        n = notes.pop_front();
        cmp_dbg(dbg_g, {~n.d, 4'hf, n.a});
      end
    end
    valid_q = valid;
  end

  initial begin
    #200us;
    fail("run did not finish");
    summarize();
  end

  // ============================================================
  // main sequence
  initial begin
    csc_note_t n;
    reset_i = 1'b1;
    {start, ack, dma, data, sat, s_do, s_clk, s_cs_n, b_do, b_clk} = '0;
    {dtr_n, rts_n, tx, tx_en, blk_a, g_en, g_out, g_oe, p_in} = '0;
    last_blk = '0;
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i) reset_i = 1'b0;
    for (int k = 0; k < 4; k++) begin
      n.kind = 1'b0;
      n.s = 8'(rnd());
      n.s[2:0] = 3'(k);
      // both byte orders and timer settings are seen; k == 3 breaks straps
      n.s[7:3] = {k != 3, k[0], 2'b00, k[1]};
      n.n = (k == 3) ? 5 : COLD;
      notes.push_back(n);
      fork
        board_i.cold_cycle(n.s, n.n);
        begin
          repeat (3) @(negedge clk_sys_i);
          {g_en, g_out, g_oe, blk_a} = 76'({rnd(), rnd(), rnd()});
          start = 1'b1;
          @(negedge clk_sys_i) start = 1'b0;
          cmp_pin({oe4, p_out, p_oe},
            {4'h0, `CSC_PIO_RST_LVL, `CSC_PIO_RST_OE});
        end
      join
      drain();
      repeat (12) begin
        @(negedge clk_sys_i);
        n.kind = 1'b1;
        n.d = 4'(rnd());
        if (n.d[3:2] == 2'b00) n.d[3] = 1'b1;
        n.a = 28'(rnd());
        {start, ack, dma, data} = n.d;
        blk_a = n.a;
        if (n.d[3]) last_blk = n.a;
        n.a = last_blk;
        notes.push_back(n);
      end
      @(negedge clk_sys_i) {start, ack} = 2'b00;
      drain();
      repeat (10) begin
        @(negedge clk_sys_i);
        {sat, s_do, s_clk, s_cs_n, b_do, b_clk, tx, tx_en} = 10'(rnd());
        {dtr_n, rts_n, g_en, g_out, g_oe, p_in} = 66'({rnd(), rnd(), rnd()});
        g_en = g_en & 16'(rnd());
        @(negedge clk_sys_i);
        cmp_pin(pin_g, pin_exp());
      end
    end
    summarize();
  end
endmodule
